// ==== core/usb_fifo_map.svh ====
`ifndef USB_FIFO_MAP_SVH
`define USB_FIFO_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_ADDR 12'h000
`define REG_PAIR 12'h004
`define REG_CTRL 12'h008
`define REG_SEL 12'h00C
`define REG_COUNT 12'h010
`define REG_STATUS 12'h014
`define REG_IRQ_EN 12'h018
`define REG_IRQ_FLAG 12'h01C
`define REG_EP_TYPE 12'h020
`define WIN_PAGE 4'h1
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_VISIBLE_BIT 0
`define SEL_DIR_BIT 7
`define STAT_OWNER_BIT 0
`define STAT_ARMED_BIT 1
`define STAT_TOGGLE_BIT 2
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define RST_ADDR 7'h00
`define RST_PAIR 4'h0
`define RST_COUNT 7'h00
`define RST_EP_TYPE 5'h00
`define RST_IRQ_EN 10'h000
`define NUM_FIFO 10
`define NUM_EP 3'h5
`define FIFO_DEPTH 7'h40
`define SETUP_LEN 7'h08
`endif

// ==== core/usb_fifo_pkg.sv ====
`include "usb_fifo_map.svh"
package usb_fifo_pkg;
   typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} tok_kind_t;
   typedef enum logic [1:0] {RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA} rsp_code_t;
   typedef enum logic [1:0] {XF_CONTROL, XF_BULK, XF_INTR} xfer_t;
   typedef enum {ST_IDLE, ST_RX, ST_TX, ST_WAIT} eng_state_t;
   typedef struct packed {
      tok_kind_t kind;
      logic [6:0] addr;
      logic [3:0] ep;
   } tok_t;
   typedef struct packed {
      rsp_code_t code;
      logic data1;
      logic [6:0] len;
   } resp_t;

   function automatic logic [3:0] fidx(input logic dir, input logic [2:0] ep);
      logic [2:0] e;
      e = (ep < `NUM_EP) ? ep : 3'h0;
      return dir ? 4'h5 + {1'b0, e} : {1'b0, e};
   endfunction : fidx

   function automatic logic fdir(input logic [3:0] f);
      return f >= 4'h5;
   endfunction : fdir

   function automatic logic [2:0] fep(input logic [3:0] f);
      logic [3:0] t;
      t = fdir(f) ? f - 4'h5 : f;
      return t[2:0];
   endfunction : fep

   function automatic logic [1:0] pair_no(input logic [3:0] f);
      return {~fdir(f), fep(f) >= 3'h3};
   endfunction : pair_no

   function automatic logic len_ok(input logic [6:0] len, input xfer_t xf);
      logic ok;
      ok = 1'b0;
      unique case (xf)
         XF_CONTROL: ok = len <= `FIFO_DEPTH;
         XF_BULK: ok = (len == 7'h08) || (len == 7'h10) || (len == 7'h20) || (len == 7'h40);
         XF_INTR: ok = (len != 7'h00) && (len <= `FIFO_DEPTH);
      endcase
      return ok;
   endfunction : len_ok
endpackage : usb_fifo_pkg

// ==== core/usb_endpoint_fifo_manager.sv ====
`timescale 1ns/1ns
`include "usb_fifo_map.svh"
module usb_endpoint_fifo_manager
   import usb_fifo_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial interface engine, token and receive side
   input wire logic tok_valid,
   input wire tok_t tok,
   input wire logic rx_start,
   input wire logic rx_data1,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_bad,
   // Serial interface engine, transmit side
   output logic resp_valid,
   output resp_t resp,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic host_ack,
   input wire logic host_timeout,
   // Pins and interrupt
   input wire logic detach_pin,
   output logic usb_irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] mem [0:639];
   logic [6:0] count [`NUM_FIFO];
   logic [9:0] owner, armed, toggle, irq_en, irq_flag;
   logic [6:0] dev_addr;
   logic [3:0] fifo_pair_control, cpu_side, eng_side;
   logic [4:0] ep_type;
   logic visible, sel_dir;
   logic [2:0] sel_ep;
   logic detach_meta, detach_sync;
   eng_state_t state;
   logic [3:0] cur_f, cur_phys;
   logic [6:0] ptr;
   logic accept, stall, is_setup, pid_ok, overflow;

   function automatic logic is_paired(input logic [3:0] f);
      return (fep(f) != 3'h0) && fifo_pair_control[pair_no(f)];
   endfunction : is_paired

   function automatic logic blocked(input logic [3:0] f);
      logic [2:0] e;
      e = fep(f);
      return is_paired(f) && !e[0];
   endfunction : blocked

   function automatic logic [3:0] phys_of(input logic [3:0] f, input logic [3:0] side);
      return (is_paired(f) && side[pair_no(f)]) ? f + 4'h1 : f;
   endfunction : phys_of

   function automatic xfer_t xfer_of(input logic [3:0] f);
      logic [2:0] e;
      e = fep(f);
      if (e == 3'h0) return XF_CONTROL;
      return ep_type[e] ? XF_INTR : XF_BULK;
   endfunction : xfer_of

   function automatic logic [9:0] onehot(input logic [3:0] f);
      return 10'h001 << f;
   endfunction : onehot

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic wr_go, apb_acc, win_hit, sel_ok, win_open, cpu_mem_we, cpu_cnt_we, mapped;
   logic [3:0] sel_f, cpu_phys, t_f, t_phys;
   logic [5:0] win_off;
   logic [6:0] next_idx;
   logic [7:0] win_byte;
   logic [31:0] rdata;
   logic tok_hit, t_ok, t_accept, t_stall, exp_pid, out_len_ok, rx_clean, rx_answer;
   logic ev_rx_begin, ev_out_end, ev_out_ok, ev_out_drop, ev_in_ok;
   logic [9:0] own_set, own_rel;

   always_comb begin
      apb_acc = psel & penable & ~pready;
      wr_go = psel & penable & pready & pwrite;
      sel_f = fidx(sel_dir, sel_ep);
      sel_ok = (sel_ep < `NUM_EP) && !blocked(sel_f);
      cpu_phys = phys_of(sel_f, cpu_side);
      win_hit = paddr[11:8] == `WIN_PAGE;
      win_off = paddr[7:2];
      win_byte = mem[{cpu_phys, win_off}];
      win_open = visible & sel_ok & ~owner[cpu_phys];
      cpu_mem_we = wr_go & win_hit & win_open;
      cpu_cnt_we = wr_go && (paddr == `REG_COUNT) && sel_ok && !owner[cpu_phys] && (pwdata[31:7] == 25'h0000000)
         && (sel_dir ? len_ok(pwdata[6:0], xfer_of(sel_f)) : pwdata[6:0] <= `FIFO_DEPTH);
      mapped = win_hit || (paddr <= `REG_EP_TYPE && paddr[1:0] == 2'h0);
   end

   always_comb begin
      rdata = 32'h00000000;
      if (win_hit) begin
         rdata = win_open ? {24'h000000, win_byte} : 32'h00000000;
      end else begin
         unique case (paddr)
            `REG_ADDR: rdata = {25'h0000000, dev_addr};
            `REG_PAIR: rdata = {28'h0000000, fifo_pair_control};
            `REG_CTRL: rdata = {31'h00000000, visible};
            `REG_SEL: rdata = {24'h000000, sel_dir, 4'h0, sel_ep};
            `REG_COUNT: rdata = {25'h0000000, count[cpu_phys]};
            `REG_STATUS: rdata = {29'h00000000, toggle[sel_f], armed[cpu_phys], owner[cpu_phys]};
            `REG_IRQ_EN: rdata = {22'h000000, irq_en};
            `REG_IRQ_FLAG: rdata = {22'h000000, irq_flag};
            `REG_EP_TYPE: rdata = {27'h0000000, ep_type};
            default: rdata = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      tok_hit = tok_valid && (state == ST_IDLE) && (tok.addr == dev_addr);
      t_f = fidx(tok.kind == TOK_IN, tok.ep[2:0]);
      t_ok = (tok.ep < 4'h5) && !blocked(t_f);
      t_phys = phys_of(t_f, eng_side);
      t_accept = t_ok && ((tok.kind == TOK_SETUP) ? (tok.ep == 4'h0)
         : (!owner[t_phys] && armed[t_phys] && xfer_of(t_f) != XF_INTR));
      t_stall = (tok.kind == TOK_OUT) && t_ok && (xfer_of(t_f) == XF_INTR);
      next_idx = ptr + 7'h01;
      exp_pid = is_setup ? 1'b0 : toggle[cur_f];
      out_len_ok = is_setup ? (ptr == `SETUP_LEN) : len_ok(ptr, xfer_of(cur_f));
      rx_clean = ~rx_bad & ~overflow & out_len_ok;
      rx_answer = ~rx_bad & ~overflow & (accept ? out_len_ok : ~is_setup);
      ev_rx_begin = (state == ST_RX) & rx_start & accept;
      ev_out_end = (state == ST_RX) & rx_end & accept;
      ev_out_ok = ev_out_end & rx_clean & pid_ok;
      ev_out_drop = ev_out_end & ~ev_out_ok;
      ev_in_ok = (state == ST_WAIT) & host_ack;
      own_set = ((cpu_cnt_we & sel_dir) ? onehot(cpu_phys) : 10'h000) | (ev_rx_begin ? onehot(cur_phys) : 10'h000);
      own_rel = (ev_out_ok | ev_in_ok) ? onehot(cur_phys) : 10'h000;
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apb_acc;
         pslverr <= apb_acc & ~mapped;
         if (apb_acc && !pwrite) begin
            prdata <= mapped ? rdata : 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detach_meta <= 1'b0;
         detach_sync <= 1'b0;
      end else begin
         detach_meta <= detach_pin;
         detach_sync <= detach_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_addr <= `RST_ADDR;
         visible <= 1'b0;
         sel_dir <= 1'b0;
         sel_ep <= 3'h0;
         irq_en <= `RST_IRQ_EN;
         ep_type <= `RST_EP_TYPE;
      end else begin
         if (detach_sync) begin
            dev_addr <= `RST_ADDR;
         end else if (wr_go && paddr == `REG_ADDR) begin
            dev_addr <= pwdata[6:0];
         end
         if (wr_go && paddr == `REG_CTRL) visible <= pwdata[`CTRL_VISIBLE_BIT];
         if (wr_go && paddr == `REG_SEL) begin
            sel_dir <= pwdata[`SEL_DIR_BIT];
            sel_ep <= pwdata[2:0];
         end
         if (wr_go && paddr == `REG_IRQ_EN) irq_en <= pwdata[9:0];
         if (wr_go && paddr == `REG_EP_TYPE) ep_type <= {pwdata[4:1], 1'b0};
      end
   end

   // ----------------------------------------
   // Pairing and active buffer pointers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_pair_control <= `RST_PAIR;
         cpu_side <= 4'h0;
         eng_side <= 4'h0;
      end else if (wr_go && paddr == `REG_PAIR) begin
         fifo_pair_control <= pwdata[3:0];
         cpu_side <= 4'h0;
         eng_side <= 4'h0;
      end else begin
         if (cpu_cnt_we && is_paired(sel_f)) cpu_side[pair_no(sel_f)] <= ~cpu_side[pair_no(sel_f)];
         if ((ev_out_ok || ev_in_ok) && is_paired(cur_f)) eng_side[pair_no(cur_f)] <= ~eng_side[pair_no(cur_f)];
      end
   end

   // ----------------------------------------
   // Ownership, counts, toggles, interrupt
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         owner <= 10'h000;
         armed <= 10'h000;
      end else begin
         owner <= (owner & ~own_rel & ~(ev_out_drop ? onehot(cur_phys) : 10'h000)) | own_set;
         armed <= (armed & ~(ev_out_ok ? onehot(cur_phys) : 10'h000))
            | ((cpu_cnt_we & ~sel_dir) ? onehot(cpu_phys) : 10'h000);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `NUM_FIFO; i++) count[i] <= `RST_COUNT;
      end else begin
         if (ev_out_ok) count[cur_phys] <= ptr;
         if (cpu_cnt_we) count[cpu_phys] <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle <= 10'h000;
      end else if (ev_out_ok && is_setup) begin
         toggle <= toggle | onehot(4'h0) | onehot(4'h5);
      end else if (ev_out_ok || ev_in_ok) begin
         toggle <= toggle ^ onehot(cur_f);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag <= 10'h000;
         usb_irq <= 1'b0;
      end else begin
         irq_flag <= (irq_flag & ~((wr_go && paddr == `REG_IRQ_FLAG) ? pwdata[9:0] : 10'h000))
            | (own_rel & owner & irq_en);
         usb_irq <= |irq_flag;
      end
   end

   always_ff @(posedge pclk) begin
      if (state == ST_RX && rx_valid && accept && ptr != `FIFO_DEPTH) mem[{cur_phys, ptr[5:0]}] <= rx_data;
      if (cpu_mem_we) mem[{cpu_phys, win_off}] <= pwdata[7:0];
   end

   // ----------------------------------------
   // Transaction engine
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         cur_f <= 4'h0;
         cur_phys <= 4'h0;
         ptr <= 7'h00;
         {accept, stall, is_setup, pid_ok, overflow} <= 5'h00;
         resp_valid <= 1'b0;
         resp <= '{RSP_NAK, 1'b0, 7'h00};
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         unique case (state)
            ST_IDLE: if (tok_hit) begin
               cur_f <= t_f;
               cur_phys <= t_phys;
               ptr <= 7'h00;
               {pid_ok, overflow} <= 2'h0;
               is_setup <= tok.kind == TOK_SETUP;
               resp_valid <= tok.kind == TOK_IN;
               if (tok.kind != TOK_IN) begin
                  state <= ST_RX;
                  accept <= t_accept;
                  stall <= t_stall;
               end else if (t_ok && owner[t_phys]) begin
                  resp <= '{RSP_DATA, toggle[t_f], count[t_phys]};
                  state <= (count[t_phys] == 7'h00) ? ST_WAIT : ST_TX;
                  tx_valid <= count[t_phys] != 7'h00;
                  tx_data <= mem[{t_phys, 6'h00}];
                  tx_last <= count[t_phys] == 7'h01;
               end else begin
                  resp <= '{RSP_NAK, 1'b0, 7'h00};
               end
            end
            ST_RX: begin
               if (rx_start) pid_ok <= rx_data1 == exp_pid;
               if (rx_valid && accept) begin
                  if (ptr == `FIFO_DEPTH) overflow <= 1'b1;
                  else ptr <= next_idx;
               end
               if (rx_end) begin
                  state <= ST_IDLE;
                  resp_valid <= rx_answer;
                  resp <= '{accept ? RSP_ACK : (stall ? RSP_STALL : RSP_NAK), 1'b0, 7'h00};
               end
            end
            ST_TX: if (tx_ready) begin
               if (tx_last) begin
                  tx_valid <= 1'b0;
                  tx_last <= 1'b0;
                  state <= ST_WAIT;
               end else begin
                  ptr <= next_idx;
                  tx_data <= mem[{cur_phys, next_idx[5:0]}];
                  tx_last <= next_idx + 7'h01 == count[cur_phys];
               end
            end
            ST_WAIT: if (host_ack || host_timeout) state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_nak_unloaded: assert property (
      tok_hit && tok.kind == TOK_IN && !owner[t_phys] |=> resp_valid && resp.code == RSP_NAK)
      else $error("IN token to unloaded FIFO not NAKed");
   chk_count_owner: assert property (
      cpu_cnt_we && sel_dir |=> owner[$past(cpu_phys)] && count[$past(cpu_phys)] == $past(pwdata[6:0]))
      else $error("Count write did not hand FIFO to engine");
   chk_rx_owner: assert property (
      ev_rx_begin |=> owner[$past(cur_phys)])
      else $error("OUT reception did not take ownership");
   chk_out_count: assert property (
      ev_out_ok |=> !owner[$past(cur_phys)] && count[$past(cur_phys)] == $past(ptr))
      else $error("OUT completion wrong ownership or count");
   chk_irq_release: assert property (
      ev_in_ok && irq_en[cur_phys] |=> irq_flag[$past(cur_phys)] ##1 usb_irq)
      else $error("Ownership release raised no interrupt");
   chk_cpu_ignore: assert property (
      wr_go && win_hit && owner[cpu_phys] && state != ST_RX |=> mem[$past({cpu_phys, win_off})] == $past(win_byte))
      else $error("CPU write reached owned FIFO");
   chk_err_silent: assert property (
      state == ST_RX && rx_end && rx_bad |=> !resp_valid)
      else $error("Errored OUT packet got a handshake");
   chk_setup_len: assert property (
      ev_out_ok && is_setup |-> ptr == `SETUP_LEN)
      else $error("Setup stage accepted with wrong length");
   chk_toggle_flip: assert property (
      ev_in_ok |=> toggle[$past(cur_f)] != $past(toggle[cur_f]))
      else $error("Data toggle not advanced");
   chk_pair_swap: assert property (
      cpu_cnt_we && is_paired(sel_f) |=> cpu_phys != $past(cpu_phys))
      else $error("Paired count write did not swap buffer");

   cov_in_packet: cover property (tok_hit && tok.kind == TOK_IN ##[1:200] ev_in_ok);
   cov_out_packet: cover property (ev_out_ok && !is_setup);
   cov_setup: cover property (ev_out_ok && is_setup);
   cov_paired: cover property (cpu_cnt_we && is_paired(sel_f));
endmodule : usb_endpoint_fifo_manager

// ==== testbench/usb_host_model.sv ====
`timescale 1ns/1ns
module usb_host_model
   import usb_fifo_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Token and receive side
   output logic tok_valid,
   output tok_t tok,
   output logic rx_start,
   output logic rx_data1,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic rx_bad,
   // Transmit side
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   output logic host_ack
);
   initial {tok_valid, tok, rx_start, rx_data1, rx_valid, rx_data, rx_end, rx_bad} = '0;

   // ------------------
   // Host requests
   // ------------------
   task automatic token(input tok_kind_t k, input logic [6:0] a, input logic [3:0] e);
      @(posedge pclk);
      tok_valid <= 1'b1;
      tok <= '{k, a, e};
      @(posedge pclk);
      tok_valid <= 1'b0;
   endtask : token

   task automatic packet(input logic d1, input logic [7:0] b[8], input logic bad);
      @(posedge pclk);
      rx_start <= 1'b1;
      rx_data1 <= d1;
      @(posedge pclk);
      rx_start <= 1'b0;
      foreach (b[i]) begin
         rx_valid <= 1'b1;
         rx_data <= b[i];
         @(posedge pclk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_end <= 1'b1;
      rx_bad <= bad;
      @(posedge pclk);
      rx_end <= 1'b0;
      rx_bad <= 1'b0;
   endtask : packet

   // ------------------
   // Stalling receiver, ACK after last byte
   // ------------------
   always @(posedge pclk) begin
      tx_ready <= 1'($urandom_range(0, 1));
      host_ack <= tx_valid && tx_last && tx_ready;
   end
endmodule : usb_host_model

// ==== testbench/tb_usb_endpoint_fifo_manager.sv ====
`timescale 1ns/1ns
`include "usb_fifo_map.svh"
module tb_usb_endpoint_fifo_manager
   import usb_fifo_pkg::*;
   ;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, detach_pin = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, tok_valid, rx_start, rx_data1, rx_valid, rx_end, rx_bad, err;
   logic resp_valid, tx_valid, tx_last, tx_ready, host_ack, usb_irq;
   logic [7:0] rx_data, tx_data;
   logic [7:0] b[8];
   logic [11:0] regs[5] = '{`REG_ADDR, `REG_PAIR, `REG_COUNT, `REG_STATUS, `REG_IRQ_FLAG};
   logic [63:0] exp_q[$];
   tok_t tok;
   resp_t resp;
   int n_errors = 0, n_tests = 0;
   localparam logic [31:0] CODE = 32'h300;

   always #20 pclk = ~pclk;

   usb_endpoint_fifo_manager dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tok_valid, .tok, .rx_start, .rx_data1, .rx_valid, .rx_data, .rx_end, .rx_bad,
      .resp_valid, .resp, .tx_valid, .tx_data, .tx_last, .tx_ready, .host_ack, .host_timeout(1'b0),
      .detach_pin, .usb_irq);
   usb_host_model u_host (.pclk, .tok_valid, .tok, .rx_start, .rx_data1, .rx_valid, .rx_data, .rx_end,
      .rx_bad, .tx_valid, .tx_last, .tx_ready, .host_ack);

   // ------------------
   // Checking
   // ------------------
   task automatic tally_and_finish();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic want(input logic [31:0] v, input logic [31:0] m = 32'hFFFFFFFF);
      exp_q.push_back({m, v});
   endtask : want

   task automatic take(input logic [31:0] seen);
      logic [63:0] e;
      if (exp_q.size() == 0) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected none", $time, seen);
      end else begin
         e = exp_q.pop_front();
         check(seen & e[63:32], e[31:0]);
      end
   endtask : take

   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0) take(prdata);
      if (resp_valid === 1'b1) take(32'(resp));
      if (tx_valid === 1'b1 && tx_ready === 1'b1) take({24'h0, tx_data});
   end

   function automatic logic [31:0] rsp(input rsp_code_t c, input logic [6:0] n);
      return {22'h0, c, 1'b0, n};
   endfunction : rsp

   // ------------------
   // Bus and wait tasks
   // ------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 40) begin
         n_errors++;
         tally_and_finish();
      end
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m = 32'hFFFFFFFF);
      want(v, m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wait_ack();
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (host_ack !== 1'b1 && k < 300);
      if (k >= 300) begin
         n_errors++;
         tally_and_finish();
      end
      repeat (3) @(posedge pclk);
   endtask : wait_ack

   // ------------------
   // Scenarios
   // ------------------
   initial begin
      void'($urandom(41));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) rd(regs[i], 32'h0);
      rd(12'h0FC, 32'h0);
      check({31'h0, err}, 32'h1);
      want(rsp(RSP_NAK, 7'h00), CODE);
      u_host.token(TOK_IN, 7'h00, 4'h1);
      wr(`REG_CTRL, 32'h1);
      wr(`REG_SEL, 32'h81);
      wr(`REG_IRQ_EN, 32'h40);
      foreach (b[i]) b[i] = 8'($urandom);
      foreach (b[i]) wr(12'h100 + 12'(4 * i), {24'h0, b[i]});
      wr(`REG_COUNT, 32'h5);
      rd(`REG_STATUS, 32'h0, 32'h1);
      wr(`REG_COUNT, 32'h8);
      rd(`REG_STATUS, 32'h1, 32'h1);
      wr(12'h100, 32'hA5);
      rd(12'h100, 32'h0);
      want(rsp(RSP_DATA, 7'h08));
      foreach (b[i]) want({24'h0, b[i]});
      u_host.token(TOK_IN, 7'h00, 4'h1);
      wait_ack();
      check({31'h0, usb_irq}, 32'h1);
      rd(`REG_STATUS, 32'h4, 32'h5);
      rd(`REG_IRQ_FLAG, 32'h40);
      wr(`REG_IRQ_FLAG, 32'h40);
      rd(`REG_IRQ_FLAG, 32'h0);
      wr(`REG_PAIR, 32'h1);
      rd(`REG_PAIR, 32'h1);
      for (int j = 0; j < 2; j++) begin
         foreach (b[i]) wr(12'h100 + 12'(4 * i), {24'h0, b[i] ^ {8{j[0]}}});
         wr(`REG_COUNT, 32'h8);
      end
      for (int j = 0; j < 2; j++) begin
         want(rsp(RSP_DATA, 7'h08), 32'h37F);
         foreach (b[i]) want({24'h0, b[i] ^ {8{j[0]}}});
         u_host.token(TOK_IN, 7'h00, 4'h1);
         wait_ack();
      end
      wr(`REG_PAIR, 32'h0);
      wr(`REG_EP_TYPE, 32'h8);
      for (int j = 3; j >= 2; j--) begin
         wr(`REG_SEL, 32'(j));
         wr(`REG_COUNT, 32'h0);
         foreach (b[i]) b[i] = 8'($urandom);
         want(rsp(j == 3 ? RSP_STALL : RSP_ACK, 7'h00), CODE);
         u_host.token(TOK_OUT, 7'h00, 4'(j));
         u_host.packet(1'b0, b, 1'b0);
      end
      rd(`REG_COUNT, 32'h8);
      rd(`REG_STATUS, 32'h4, 32'h5);
      foreach (b[i]) rd(12'h100 + 12'(4 * i), {24'h0, b[i]});
      wr(`REG_COUNT, 32'h0);
      want(rsp(RSP_ACK, 7'h00), CODE);
      u_host.token(TOK_OUT, 7'h00, 4'h2);
      u_host.packet(1'b0, b, 1'b0);
      rd(`REG_COUNT, 32'h0);
      rd(`REG_STATUS, 32'h6, 32'h7);
      want(rsp(RSP_ACK, 7'h00), CODE);
      for (int j = 1; j >= 0; j--) begin
         u_host.token(TOK_SETUP, 7'h00, 4'h0);
         u_host.packet(1'b0, b, j[0]);
      end
      wr(`REG_ADDR, 32'h15);
      rd(`REG_ADDR, 32'h15);
      want(rsp(RSP_NAK, 7'h00), CODE);
      u_host.token(TOK_IN, 7'h00, 4'h4);
      u_host.token(TOK_IN, 7'h15, 4'h4);
      repeat (3) @(posedge pclk);
      detach_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(`REG_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(exp_q.size()), 32'h0);
      tally_and_finish();
   end
endmodule : tb_usb_endpoint_fifo_manager
